// file: sfl_pkg.sv
// Constants and types for the shift and flag load unit
//==============================================================
// Operation
// (RQ1) The count is one for the single-count opcodes, count_low_byte for the register forms, imm8 otherwise.
// (RQ2) The group extension field selects left shift at 4, logical right at 5 and signed right at 7.
// (RQ3) Every count is cut to its five low bits, giving 0 to 31.
// (RQ4) The carry flag ends holding the last bit shifted out of the operand.
// (RQ5) Left shifts push the top bit toward the carry and clear the vacated low bits.
// (RQ6) Logical right shifts push the low bit toward the carry and fill the top with zero.
// (RQ7) Signed right shifts fill the vacated top bits with the original sign bit.
// (RQ8) A one-bit left shift sets overflow when the result top bit differs from the new carry.
// (RQ9) A one-bit signed right shift clears overflow.
// (RQ10) A one-bit logical right shift sets overflow to the original top bit.
// (RQ11) Opcode 9E loads sign, zero, aux carry, parity and carry from accum_high_byte bits 7,6,4,2,0.
// (RQ12) That load forces status_word bits 1, 3 and 5 to 1, 0 and 0.
// (RQ13) That load takes two clock cycles and never reports an exception.
// (RQ14) A nonzero count sets sign, zero and parity from the result; a zero count changes no flag.
// (RQ15) Overflow after multi-bit shifts and carry after over-wide shifts are undefined.
// (RQ16) Undefined flags still take a deterministic value.
package sfl_pkg;
	localparam logic [7:0] OPC_SHIFT_B_ONE = 8'hD0;
	localparam logic [7:0] OPC_SHIFT_V_ONE = 8'hD1;
	localparam logic [7:0] OPC_SHIFT_B_CNT = 8'hD2;
	localparam logic [7:0] OPC_SHIFT_V_CNT = 8'hD3;
	localparam logic [7:0] OPC_SHIFT_B_IMM = 8'hC0;
	localparam logic [7:0] OPC_SHIFT_V_IMM = 8'hC1;
	localparam logic [7:0] OPC_FLAG_LOAD   = 8'h9E;
	localparam logic [2:0] EXT_LEFT        = 3'h4;
	localparam logic [2:0] EXT_LOG_RIGHT   = 3'h5;
	localparam logic [2:0] EXT_SGN_RIGHT   = 3'h7;
	localparam logic [4:0] COUNT_MASK      = 5'h1F;
	localparam logic [7:0] COUNT_ONE       = 8'h01;
	localparam int FLAG_LOAD_CYCLES        = 2;
	// Status word bit positions
	localparam int FB_CARRY = 0;
	localparam int FB_RSV1  = 1;
	localparam int FB_PAR   = 2;
	localparam int FB_RSV3  = 3;
	localparam int FB_AUX   = 4;
	localparam int FB_RSV5  = 5;
	localparam int FB_ZERO  = 6;
	localparam int FB_SIGN  = 7;
	localparam int FB_OVF   = 11;
	localparam logic RSV1_VAL = 1'b1;
	localparam logic RSV3_VAL = 1'b0;
	localparam logic RSV5_VAL = 1'b0;
	// Register map, byte addresses
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_COUNT  = 8'h08;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_FILL   = 1;
	localparam logic [1:0]  CTRL_RESET  = 2'h1;
	localparam int ST_BUSY_BIT = 16;
	localparam int ST_ILL_BIT  = 17;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} sfl_size_e;
	typedef enum logic [1:0] {OP_LEFT, OP_LOG_RIGHT, OP_SGN_RIGHT} sfl_op_e;
	typedef enum logic {ST_IDLE = 1'b0, ST_LOAD = 1'b1} sfl_state_e;
endpackage

// file: sfl_shift_core.sv
// Barrel shifter with last-bit-out capture for 8, 16 and 32 bit operands
`timescale 1ns/1ns
module sfl_shift_core
	import sfl_pkg::*;
(
	input  wire logic [31:0] operand,
	input  sfl_size_e        size,
	input  sfl_op_e          op,
	input  wire logic [4:0]  count,
	output logic [31:0]      result,
	output logic             carry_out,
	output logic             orig_msb
);
	logic [31:0] width_mask;
	logic [31:0] src;
	logic        sgn_fill;
	logic [31:0] src_ext;
	logic [64:0] left_wide;
	logic [64:0] right_wide;
	logic        left_carry;

	assign width_mask = (size == SZ_BYTE) ? 32'h000000FF :
		(size == SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
	assign src = operand & width_mask;
	assign orig_msb = (size == SZ_BYTE) ? operand[7] :
		(size == SZ_WORD) ? operand[15] : operand[31];
	assign sgn_fill = (op == OP_SGN_RIGHT) & orig_msb; // RQ7
	assign src_ext = sgn_fill ? (src | ~width_mask) : src;

	// Bits above the operand catch what leaves the top
	assign left_wide = {33'h0, src} << count; // RQ5
	assign left_carry = (size == SZ_BYTE) ? left_wide[8] :
		(size == SZ_WORD) ? left_wide[16] : left_wide[32];
	// A spare low bit catches the last bit out; the sign-filled top
	// half covers every count up to 31, so no extra fill mask is needed
	assign right_wide = {{32{sgn_fill}}, src_ext, 1'b0} >> count; // RQ6 RQ7

	assign result = ((op == OP_LEFT) ? left_wide[31:0] : right_wide[32:1]) & width_mask;
	// Over-wide shifts give zero (or the sign) rather than a random carry
	assign carry_out = (op == OP_LEFT) ? left_carry : right_wide[0]; // RQ4 RQ16
endmodule

// file: sfl_flag_eval.sv
// Sign, zero and parity evaluation of a shift result
`timescale 1ns/1ns
module sfl_flag_eval
	import sfl_pkg::*;
(
	input  wire logic [31:0] result,
	input  sfl_size_e        size,
	output logic             sign,
	output logic             zero,
	output logic             parity
);
	wire logic [8:0] par_chain;

	assign sign = (size == SZ_BYTE) ? result[7] :
		(size == SZ_WORD) ? result[15] : result[31];
	assign zero = (result == 32'h00000000);
	// Parity looks at the low byte only, set when the count of ones is even
	assign par_chain[0] = 1'b1;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_par
			assign par_chain[i + 1] = par_chain[i] ^ result[i];
		end
	endgenerate
	assign parity = par_chain[8];
endmodule

// file: sfl_unit.sv
// Shift and flag load execution slice with an AHB-Lite control port
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module sfl_unit
	import sfl_pkg::*;
#(
	parameter int OP_CNT_W = 32
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Decoder side
	input  wire logic        op_valid,
	output logic             op_ready,
	input  wire logic [7:0]  opcode,
	input  wire logic [2:0]  modrm_reg,
	input  wire logic        opsize_32,
	input  wire logic [31:0] operand,
	input  wire logic [7:0]  count_low_byte,
	input  wire logic [7:0]  imm8,
	input  wire logic [7:0]  accum_high_byte,
	input  wire logic [31:0] status_word,
	// Writeback side
	output logic             done_valid,
	output logic [31:0]      done_result,
	output logic             result_write,
	output logic [31:0]      status_word_out,
	output logic             op_illegal
);

	//==========================================================
	// Parameter check
	generate
		if (OP_CNT_W < 1 || OP_CNT_W > 32) begin : g_bad_cnt
			$error("OP_CNT_W must lie between 1 and 32");
		end
	endgenerate

	//==========================================================
	// Declarations
	logic [1:0]          ctrl_reg;
	logic [1:0]          ctrl_next;
	sfl_state_e          state_reg;
	sfl_state_e          state_next;
	logic [31:0]         load_hold_reg;
	logic                done_valid_reg;
	logic [31:0]         done_result_reg;
	logic                result_write_reg;
	logic [31:0]         status_out_reg;
	logic                op_illegal_reg;
	logic                last_ill_reg;
	logic [OP_CNT_W-1:0] op_count_reg;
	logic                wr_pend_reg;
	logic [7:0]          wr_addr_reg;
	logic [31:0]         hrdata_reg;

	wire logic           unit_enable;
	wire logic           fill_val;
	wire logic           is_byte_grp;
	wire logic           is_wide_grp;
	wire logic           is_shift_opc;
	wire logic           is_one_form;
	wire logic           is_cl_form;
	wire logic           ext_legal;
	wire logic           is_shift;
	wire logic           is_load;
	wire logic           is_illegal;
	wire logic [7:0]     count_raw;
	wire logic [4:0]     eff_count;
	wire logic           count_zero;
	wire logic           count_one;
	wire sfl_size_e      op_size;
	wire sfl_op_e        shift_op;
	wire logic           accept;
	wire logic           take_shift;
	wire logic           take_load;
	wire logic           take_bad;

	wire logic [31:0]    sh_result;
	wire logic           sh_carry;
	wire logic           sh_orig_msb;
	wire logic           res_sign;
	wire logic           res_zero;
	wire logic           res_parity;
	wire logic           ovf_val;
	wire logic [31:0]    shift_sw;
	wire logic [31:0]    load_sw;

	wire logic           ahb_take;
	wire logic           ahb_wr;
	wire logic [7:0]     ahb_addr;
	wire logic [31:0]    status_view;
	wire logic [31:0]    rd_mux;

	//==========================================================
	// Instruction decode
	assign is_byte_grp = (opcode == OPC_SHIFT_B_ONE) || (opcode == OPC_SHIFT_B_CNT) ||
		(opcode == OPC_SHIFT_B_IMM);
	assign is_wide_grp = (opcode == OPC_SHIFT_V_ONE) || (opcode == OPC_SHIFT_V_CNT) ||
		(opcode == OPC_SHIFT_V_IMM);
	assign is_shift_opc = is_byte_grp || is_wide_grp;
	assign is_one_form = (opcode == OPC_SHIFT_B_ONE) || (opcode == OPC_SHIFT_V_ONE);
	assign is_cl_form = (opcode == OPC_SHIFT_B_CNT) || (opcode == OPC_SHIFT_V_CNT);
	// Extension 6 is left undecoded on purpose and reported as illegal
	assign ext_legal = (modrm_reg == EXT_LEFT) || (modrm_reg == EXT_LOG_RIGHT) ||
		(modrm_reg == EXT_SGN_RIGHT); // RQ2
	assign is_shift = is_shift_opc && ext_legal;
	assign is_load = (opcode == OPC_FLAG_LOAD);
	assign is_illegal = !is_shift && !is_load;

	assign count_raw = is_one_form ? COUNT_ONE :
		(is_cl_form ? count_low_byte : imm8); // RQ1
	assign eff_count = count_raw[4:0] & COUNT_MASK; // RQ3
	assign count_zero = (eff_count == 5'h00);
	assign count_one = (eff_count == 5'h01);

	assign op_size = is_byte_grp ? SZ_BYTE : (opsize_32 ? SZ_DWORD : SZ_WORD); // RQ2
	assign shift_op = (modrm_reg == EXT_LEFT) ? OP_LEFT :
		((modrm_reg == EXT_SGN_RIGHT) ? OP_SGN_RIGHT : OP_LOG_RIGHT); // RQ2

	//==========================================================
	// Handshake
	// A disabled unit holds op_ready low, so the decoder stalls instead of losing work
	assign unit_enable = ctrl_reg[CTRL_ENABLE];
	assign fill_val = ctrl_reg[CTRL_FILL];
	// A second request waits while the flag load finishes its second cycle
	assign op_ready = unit_enable && (state_reg == ST_IDLE);
	assign accept = op_valid && op_ready;
	assign take_shift = accept && is_shift;
	assign take_load = accept && is_load;
	assign take_bad = accept && is_illegal;

	//==========================================================
	// Shift datapath
	sfl_shift_core u_core (
		.operand   (operand),
		.size      (op_size),
		.op        (shift_op),
		.count     (eff_count),
		.result    (sh_result),
		.carry_out (sh_carry),
		.orig_msb  (sh_orig_msb)
	);

	sfl_flag_eval u_flags (
		.result (sh_result),
		.size   (op_size),
		.sign   (res_sign),
		.zero   (res_zero),
		.parity (res_parity)
	);

	// Multi-bit shifts take the software chosen fill, so a reference
	// model can mask overflow without chasing stale values
	assign ovf_val = !count_one ? fill_val : // RQ15 RQ16
		(shift_op == OP_LEFT) ? (res_sign ^ sh_carry) : // RQ8
		(shift_op == OP_SGN_RIGHT) ? 1'b0 : // RQ9
		sh_orig_msb; // RQ10

	// Aux carry is kept as it was on shifts
	assign shift_sw = count_zero ? status_word : { // RQ14
		status_word[31:FB_OVF + 1],
		ovf_val,
		status_word[FB_OVF - 1:FB_SIGN + 1],
		res_sign,
		res_zero,
		status_word[FB_RSV5:FB_AUX],
		status_word[FB_RSV3],
		res_parity,
		status_word[FB_RSV1],
		sh_carry
	}; // RQ4 RQ14

	assign load_sw = {
		status_word[31:FB_SIGN + 1],
		accum_high_byte[FB_SIGN],
		accum_high_byte[FB_ZERO],
		RSV5_VAL,
		accum_high_byte[FB_AUX],
		RSV3_VAL,
		accum_high_byte[FB_PAR],
		RSV1_VAL,
		accum_high_byte[FB_CARRY]
	}; // RQ11 RQ12

	//==========================================================
	// Sequencing
	// The load spends one cycle in the hold stage so its answer shows at
	// the second edge, matching its documented two-cycle cost
	assign state_next = take_load ? ST_LOAD : ST_IDLE; // RQ13

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			load_hold_reg <= 32'h00000000;
		end else if (take_load) begin
			load_hold_reg <= load_sw; // RQ11
		end
	end

	//==========================================================
	// Writeback outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			done_valid_reg <= 1'b0;
		end else begin
			done_valid_reg <= take_shift || take_bad || (state_reg == ST_LOAD);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			result_write_reg <= 1'b0;
		end else begin
			result_write_reg <= take_shift;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			op_illegal_reg <= 1'b0;
		end else begin
			// The load never reports an exception
			op_illegal_reg <= take_bad; // RQ13
		end
	end

	// The pulse is gone before software can read it, so the status
	// register keeps the outcome of the last completion instead
	always_ff @(posedge clk) begin
		if (rst) begin
			last_ill_reg <= 1'b0;
		end else if (done_valid_reg) begin
			last_ill_reg <= op_illegal_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_result_reg <= 32'h00000000;
		end else if (take_shift) begin
			done_result_reg <= sh_result;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_out_reg <= 32'h00000000;
		end else if (take_shift) begin
			status_out_reg <= shift_sw;
		end else if (take_bad) begin
			status_out_reg <= status_word;
		end else if (state_reg == ST_LOAD) begin
			status_out_reg <= load_hold_reg; // RQ13
		end
	end

	// Counts every completion, illegal ones too; wraps at its width
	always_ff @(posedge clk) begin
		if (rst) begin
			op_count_reg <= '0;
		end else if (done_valid_reg) begin
			op_count_reg <= op_count_reg + 1'b1;
		end
	end

	assign done_valid = done_valid_reg;
	assign done_result = done_result_reg;
	assign result_write = result_write_reg;
	assign status_word_out = status_out_reg;
	assign op_illegal = op_illegal_reg;

	//==========================================================
	// AHB-Lite register port
	// Zero wait states; only whole-word accesses are meaningful
	assign ahb_take = hsel && hready && htrans[1];
	assign ahb_wr = ahb_take && hwrite;
	assign ahb_addr = haddr[7:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ahb_wr;
			wr_addr_reg <= ahb_addr;
		end
	end

	// Only the control word is writable; other writes are dropped
	assign ctrl_next = (wr_pend_reg && (wr_addr_reg == ADDR_CTRL)) ?
		hwdata[1:0] : ctrl_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Busy and last-illegal sit just above the low half of the last status word
	assign status_view = {
		14'h0000,
		last_ill_reg,
		(state_reg != ST_IDLE),
		status_out_reg[15:0]
	};
	// Reading through ctrl_next returns a write made just before
	assign rd_mux = (ahb_addr == ADDR_CTRL) ? {30'h00000000, ctrl_next} :
		(ahb_addr == ADDR_STATUS) ? status_view :
		(ahb_addr == ADDR_COUNT) ? 32'(op_count_reg) : 32'h00000000;

	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata_reg <= 32'h00000000;
		end else if (ahb_take && !hwrite) begin
			hrdata_reg <= rd_mux;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	// No access can fail in this register map, so the response is always OKAY
	assign hresp = 1'b0;

endmodule

// file: sfl_unit_assertions.sv
// Concurrent checks on the ports of the shift and flag load unit
`timescale 1ns/1ns
module sfl_unit_chk
	import sfl_pkg::*;
#(
	parameter int OP_CNT_W = 32
)
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        op_valid,
	input wire logic        op_ready,
	input wire logic [7:0]  opcode,
	input wire logic [2:0]  modrm_reg,
	input wire logic        opsize_32,
	input wire logic [31:0] operand,
	input wire logic [7:0]  count_low_byte,
	input wire logic [7:0]  imm8,
	input wire logic [7:0]  accum_high_byte,
	input wire logic [31:0] status_word,
	input wire logic        done_valid,
	input wire logic [31:0] done_result,
	input wire logic        result_write,
	input wire logic [31:0] status_word_out,
	input wire logic        op_illegal
);
	//==============================================================
	// Decode of the request as the unit should see it
	wire       is_one  = opcode == OPC_SHIFT_B_ONE || opcode == OPC_SHIFT_V_ONE;
	wire       is_cl   = opcode == OPC_SHIFT_B_CNT || opcode == OPC_SHIFT_V_CNT;
	wire       is_imm  = opcode == OPC_SHIFT_B_IMM || opcode == OPC_SHIFT_V_IMM;
	wire [4:0] eff     = (is_one ? 5'h01 : is_cl ? count_low_byte[4:0] : imm8[4:0]) & COUNT_MASK;
	wire       ext_ok  = modrm_reg inside {EXT_LEFT, EXT_LOG_RIGHT, EXT_SGN_RIGHT};
	wire       dw      = opsize_32 && !(opcode inside {8'hD0, 8'hD2, 8'hC0});
	wire       take    = op_valid && op_ready;
	wire       take_sh = take && (is_one || is_cl || is_imm) && ext_ok;
	wire       take_ld = take && opcode == OPC_FLAG_LOAD;
	wire       dw_one  = take_sh && dw && eff == 5'h01;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	//==============================================================
	// Properties
	sequence s_ld_take;
		take_ld;
	endsequence
	sequence s_ld_answer;
		!done_valid ##1 done_valid;
	endsequence

	a_shift_answer: assert property (take_sh |=> done_valid && result_write && !op_illegal)
		else $error("shift not answered in one cycle");
	a_load_two_cycles: assert property (s_ld_take |=> s_ld_answer)
		else $error("flag load latency wrong");
	a_load_no_fault: assert property (s_ld_take |-> ##2 !op_illegal && !result_write)
		else $error("flag load raised a fault");
	a_load_fields: assert property (s_ld_take |-> ##2 (status_word_out[7:0] & 8'hD5) ==
		($past(accum_high_byte, 2) & 8'hD5)) else $error("flag load fields wrong");
	a_load_fixed_bits: assert property (s_ld_take |-> ##2
		(status_word_out[5:1] & 5'h15) == 5'h01) else $error("fixed bits wrong after flag load");
	a_zero_count_keeps: assert property (take_sh && eff == 5'h00 |=>
		status_word_out == $past(status_word)) else $error("zero count changed flags");
	a_zero_flag_set: assert property (take_sh && eff != 5'h00 |=>
		status_word_out[FB_ZERO] == (done_result == 32'h0)) else $error("zero flag wrong");
	a_signed_one_ovf: assert property (take_sh && eff == 5'h01 && modrm_reg == EXT_SGN_RIGHT
		|=> !status_word_out[FB_OVF]) else $error("signed right overflow not cleared");
	a_logic_one_ovf: assert property (dw_one && modrm_reg == EXT_LOG_RIGHT |=>
		status_word_out[FB_OVF] == $past(operand[31])) else $error("logical right overflow wrong");
	a_left_one_ovf: assert property (dw_one && modrm_reg == EXT_LEFT |=> status_word_out[FB_OVF]
		== (done_result[31] ^ status_word_out[FB_CARRY])) else $error("left overflow wrong");
	a_left_one_carry: assert property (dw_one && modrm_reg == EXT_LEFT |=>
		status_word_out[FB_CARRY] == $past(operand[31]) && done_result == {$past(operand[30:0]), 1'b0})
		else $error("left shift carry or result wrong");
	a_logic_zero_fill: assert property (take_sh && dw && eff != 5'h00 &&
		modrm_reg == EXT_LOG_RIGHT |=> !done_result[31]) else $error("logical right top not zero");
endmodule

bind sfl_unit sfl_unit_chk #(.OP_CNT_W(OP_CNT_W)) u_chk (.clk, .rst, .op_valid, .op_ready,
	.opcode, .modrm_reg, .opsize_32, .operand, .count_low_byte, .imm8, .accum_high_byte,
	.status_word, .done_valid, .done_result, .result_write, .status_word_out, .op_illegal);

// file: sfl_wb_model.sv
// Writeback model that holds the status word fed back to the unit
`timescale 1ns/1ns
module sfl_wb_model
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        done_valid,
	input  wire logic [31:0] status_word_out,
	output logic [31:0]      status_word
);
	// Untouched bits start non-zero so that pass-through errors show
	always_ff @(posedge clk) begin
		if (rst) begin
			status_word <= 32'h00000A53;
		end else if (done_valid) begin
			status_word <= status_word_out;
		end
	end
endmodule

// file: tb.sv
// Self-checking testbench for the shift and flag load unit
`timescale 1ns/1ns
module tb;
	import sfl_pkg::*;
	logic        clk, rst, hsel, hwrite, hreadyout, hresp, op_valid, op_ready, opsize_32;
	logic        done_valid, result_write, op_illegal, fill;
	logic [1:0]  htrans;
	logic [2:0]  hsize, modrm_reg;
	logic [7:0]  opcode, count_low_byte, imm8, accum_high_byte;
	logic [31:0] haddr, hwdata, hrdata, operand, status_word, done_result, status_word_out;
	wire         hready = hreadyout;
	int          error_cnt, n_compared, ndone;
	logic [7:0]  tbl [6] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1};
	logic [2:0]  exts [3] = '{EXT_LEFT, EXT_LOG_RIGHT, EXT_SGN_RIGHT};
	logic [7:0]  cnts [9] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h08, 8'h10, 8'h1F, 8'h20, 8'hFF};

	sfl_unit #(.OP_CNT_W(32)) dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .op_valid, .op_ready, .opcode, .modrm_reg,
		.opsize_32, .operand, .count_low_byte, .imm8, .accum_high_byte, .status_word,
		.done_valid, .done_result, .result_write, .status_word_out, .op_illegal);
	sfl_wb_model wb (.clk, .rst, .done_valid, .status_word_out, .status_word);

	//==============================================================
	// Reference, comparison and closing
	function automatic logic [31:0] ref_sw(input logic [7:0] opc, input logic [2:0] ext,
		input logic o32, input logic [31:0] v, input logic [7:0] cl, im, ah,
		input logic [31:0] sw, output logic [31:0] res);
		int w;
		logic [4:0] c;
		logic [31:0] m, x;
		logic cf, top;
		w = (opc inside {8'hD0, 8'hD2, 8'hC0}) ? 8 : (o32 ? 32 : 16);
		c = (opc inside {8'hD0, 8'hD1}) ? 5'h01 : (opc inside {8'hD2, 8'hD3}) ? cl[4:0] : im[4:0];
		m = 32'hFFFFFFFF >> (32 - w);
		x = v & m;
		top = x[w-1];
		cf = 1'b0;
		res = x;
		if (opc == OPC_FLAG_LOAD) return (sw & ~32'hFF) | {24'h0, ah & 8'hD5} | 32'h2;
		if (!(opc inside {tbl}) || !(ext inside {exts})) return sw;
		for (int i = 0; i < c; i++) begin
			cf = (ext == EXT_LEFT) ? x[w-1] : x[0];
			x = (ext == EXT_LEFT) ? (x << 1) & m
				: (x >> 1) | ({31'h0, ext == EXT_SGN_RIGHT && top} << (w - 1));
		end
		res = x;
		if (c == 5'h00) return sw;
		sw[FB_CARRY] = cf;
		sw[FB_SIGN] = x[w-1];
		sw[FB_ZERO] = x == 32'h0;
		sw[FB_PAR] = ~^x[7:0];
		sw[FB_OVF] = (c != 5'h01) ? fill : (ext == EXT_LEFT) ? x[w-1] ^ cf
			: (ext == EXT_LOG_RIGHT) ? top : 1'b0;
		return sw;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		int n;
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin error_cnt++; end_of_test(); end
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
		r = hrdata;
		if (hready !== 1'b1) begin error_cnt++; end_of_test(); end
	endtask

	task automatic op(input logic [7:0] opc, input logic [2:0] ext, input logic o32,
		input logic [31:0] v, input logic [7:0] cl, im);
		logic [31:0] es, er;
		logic lg, ld;
		int n;
		ld = opc == OPC_FLAG_LOAD;
		lg = ld || ((opc inside {tbl}) && (ext inside {exts}));
		@(posedge clk);
		op_valid <= 1'b1;
		opcode <= opc;
		modrm_reg <= ext;
		opsize_32 <= o32;
		operand <= v;
		count_low_byte <= cl;
		imm8 <= im;
		accum_high_byte <= 8'($urandom);
		n = 0;
		do begin @(posedge clk); n++; end while (op_ready !== 1'b1 && n < 20);
		if (op_ready !== 1'b1) begin error_cnt++; end_of_test(); end
		es = ref_sw(opc, ext, o32, v, cl, im, accum_high_byte, status_word, er);
		op_valid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end while (done_valid !== 1'b1 && n < 8);
		if (n >= 8) begin error_cnt++; end_of_test(); end
		ndone++;
		chk("latency", 32'(n), ld ? 32'd2 : 32'd1);
		chk("status", status_word_out, es);
		chk("pulses", {30'h0, result_write, op_illegal}, {30'h0, lg && !ld, !lg});
		if (lg && !ld) chk("result", done_result, er);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	//==============================================================
	// Main sequence
	initial begin
		logic [31:0] r;
		int k;
		void'($urandom(73));
		rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
		hwdata = 32'h0; op_valid = 1'b0; opcode = 8'h0; modrm_reg = 3'h0; opsize_32 = 1'b0;
		operand = 32'h0; count_low_byte = 8'h0; imm8 = 8'h0; accum_high_byte = 8'h0;
		fill = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk("sw reset", status_word_out, 32'h0);
		ahb(1'b0, 32'(ADDR_CTRL), 32'h0, r);
		chk("ctrl reset", r, 32'h1);
		for (int i = 0; i < 130; i++) begin
			k = (i < 54) ? cnts[i % 9] : $urandom;
			if (i == 70) begin
				ahb(1'b1, 32'(ADDR_CTRL), 32'h3, r);
				fill = 1'b1;
				ahb(1'b0, 32'(ADDR_CTRL), 32'h0, r);
				chk("ctrl", r, 32'h3);
			end
			op(tbl[i % 6], exts[(i / 6) % 3], (i < 54) ? (i / 18) != 0 : 1'($urandom),
				(i % 5 == 0) ? 32'hFFFFFFF7 : $urandom, 8'(k), ~8'(k));
		end
		repeat (6) op(OPC_FLAG_LOAD, 3'h0, 1'b1, $urandom, 8'h0, 8'h0);
		// A disabled unit must refuse work until it is enabled again
		ahb(1'b1, 32'(ADDR_CTRL), 32'h2, r);
		@(posedge clk);
		op_valid <= 1'b1;
		repeat (4) begin
			@(posedge clk);
			chk("refused", {30'h0, op_ready, done_valid}, 32'h0);
		end
		op_valid <= 1'b0;
		ahb(1'b1, 32'(ADDR_CTRL), 32'h3, r);
		op(OPC_SHIFT_V_ONE, 3'h6, 1'b1, $urandom, 8'h0, 8'h0);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0, r);
		chk("illegal bit", {31'h0, r[ST_ILL_BIT]}, 32'h1);
		op(8'h90, EXT_LEFT, 1'b1, $urandom, 8'h0, 8'h0);
		ahb(1'b0, 32'(ADDR_COUNT), 32'h0, r);
		chk("count", r, 32'(ndone));
		ahb(1'b0, 32'h0C, 32'h0, r);
		chk("unmapped", r, 32'h0);
		end_of_test();
	end
endmodule
